// ### verilog/boot_lock_regs.svh
`ifndef BOOT_LOCK_REGS_SVH
`define BOOT_LOCK_REGS_SVH
`define APP_RESET_ADDR 15'h0000
`define LOADER_START_WORD 15'h3800
`define WORD_FIELD_LSB 1
`define WORD_FIELD_MSB 5
`define PAGE_FIELD_LSB 6
`define PAGE_FIELD_MSB 15
`define LOCK_ERASED 4'hf
`define LOCK_DATA_LSB 2
`define LOCK_DATA_MSB 5
`define FUSE_ERASED 1'b1
`define PROG_CYCLES 8'h08
`endif

// ### verilog/boot_lock_pkg.sv
package boot_lock_pkg;
  typedef enum logic [1:0] {
    CMD_PAGE_ERASE,
    CMD_PAGE_LOAD,
    CMD_PAGE_WRITE,
    CMD_LOCK_SET
  } store_cmd_t;
  typedef enum logic {
    ST_IDLE,
    ST_PROG
  } prog_state_t;
endpackage

// ### verilog/section_access_check.sv
`timescale 1ns/10ps
module section_access_check (
  input wire logic isStore, // 1 store, 0 load
  input wire logic execInLoader, // running code sits in loader section
  input wire logic targetInLoader, // target address in loader section
  input wire logic [1:0] appLock, // {hi, lo} application pair
  input wire logic [1:0] bootLock, // {hi, lo} loader pair
  output logic allow // access may proceed
);
  logic [1:0] mode;
  logic writeOk;
  logic readOk;
  assign mode = targetInLoader ? bootLock : appLock;
  // low bit programmed means modes 2 or 3
  assign writeOk = execInLoader & mode[0];
  // high bit programmed means modes 3 or 4, only cross-section loads barred
  assign readOk = mode[1] | (execInLoader == targetInLoader);
  assign allow = isStore ? writeOk : readOk;
endmodule // section_access_check

// ### verilog/lock_bit_store.sv
`timescale 1ns/10ps
`include "boot_lock_regs.svh"
module lock_bit_store (
  input wire logic core_clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic loadNv, // take nonvolatile image
  input wire logic [3:0] nvBits, // stored lock image
  input wire logic progStrobe, // software programming
  input wire logic [3:0] progMask, // 0 bits get programmed
  input wire logic extStrobe, // external programmer write
  input wire logic [3:0] extMask, // 0 bits get programmed
  input wire logic chipErase, // chip erase command
  output logic [3:0] lockBits // current lock bits
);
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_bit
      logic progHit;
      assign progHit = (progStrobe & ~progMask[i]) | (extStrobe & ~extMask[i]);
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          lockBits[i] <= 1'(`LOCK_ERASED >> i);
        end else if (chipErase) begin
          lockBits[i] <= 1'b1;
        end else if (loadNv) begin
          lockBits[i] <= nvBits[i];
        end else if (progHit) begin
          lockBits[i] <= 1'b0; // programming only moves 1 to 0
        end
      end
    end
  endgenerate
endmodule // lock_bit_store

// ### verilog/boot_lock_flash_guard.sv
`timescale 1ns/10ps
`include "boot_lock_regs.svh"
module boot_lock_flash_guard (
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic sys_rst, // async reset, high
  input wire logic [3:0] nvLockBits, // stored lock image {bootHi,bootLo,appHi,appLo}
  input wire logic nvBootResetFuse, // stored boot reset fuse
  input wire logic chipErase, // external chip erase pulse
  input wire logic extLockWrite, // external lock programming pulse
  input wire logic [3:0] extLockData, // 0 bits get programmed
  input wire logic extFuseWrite, // external fuse programming pulse
  input wire logic extFuseData, // new fuse value
  input wire logic [14:0] execPc, // word address of executing code
  input wire logic vectorsInLoader, // interrupt vectors in loader section
  input wire logic [7:0] pointerHighByte, // pointer high byte
  input wire logic [7:0] pointerLowByte, // pointer low byte
  input wire logic storeReq, // store_program_memory issued, pulse
  input wire boot_lock_pkg::store_cmd_t storeCmd, // store command
  input wire logic [7:0] storeData, // data byte for lock set
  input wire logic loadReq, // program-memory load issued, pulse
  output logic progStart, // erase or write begins, pulse
  output logic progDone, // erase or write ends, pulse
  output logic progBusy, // programming in progress
  output boot_lock_pkg::store_cmd_t progCmd, // latched command
  output logic [9:0] latchedPage, // latched page address
  output logic [4:0] latchedWord, // latched word in page
  output logic wordLoad, // temp buffer word write, pulse
  output logic storeRefused, // store dropped, pulse
  output logic loadGrant, // load may read flash, pulse
  output logic loadRefused, // load blocked, pulse
  output logic [15:0] loadByteAddr, // byte address of granted load
  output logic loadHighByte, // byte select of granted load
  output logic intSuppress, // interrupts held off
  output logic [14:0] resetVector, // word address after reset
  output logic [3:0] lockImage, // lock bits to persist
  output logic bootResetFuse // fuse value to persist
);
  import boot_lock_pkg::*;

  prog_state_t state;
  prog_state_t next_state;
  logic [7:0] progCount;
  logic nvPending;
  logic [3:0] lockBits;
  logic [15:0] pointer;
  logic [14:0] targetWord;
  logic execInLoader;
  logic targetInLoader;
  logic storeAllow;
  logic loadAllow;
  logic isProgCmd;
  logic isLockSet;
  logic isPageLoad;
  logic storeFromApp;
  logic storeTake;
  logic startProg;
  logic lockStrobe;
  logic progEnd;
  logic appVecCase;
  logic bootVecCase;
  logic next_intSuppress;
  logic [3:0] lockMask;

  // nonvolatile images are caught once, right after reset release
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvPending <= 1'b1;
    end else begin
      nvPending <= 1'b0;
    end
  end

  // pointer decode
  assign pointer = {pointerHighByte, pointerLowByte};
  assign targetWord = pointer[15:1];
  assign execInLoader = execPc >= `LOADER_START_WORD;
  assign targetInLoader = targetWord >= `LOADER_START_WORD;

  // command decode
  assign isLockSet = storeCmd == CMD_LOCK_SET;
  assign isPageLoad = storeCmd == CMD_PAGE_LOAD;
  assign isProgCmd = (storeCmd == CMD_PAGE_ERASE) || (storeCmd == CMD_PAGE_WRITE);
  assign storeFromApp = storeReq & ~execInLoader;
  // new stores are dropped while an operation owns the latched address
  assign storeTake = storeReq & execInLoader & (state == ST_IDLE);
  assign startProg = storeTake & isProgCmd & storeAllow;
  // lock set uses only the data byte, never the pointer
  assign lockStrobe = storeTake & isLockSet;
  assign lockMask = storeData[`LOCK_DATA_MSB:`LOCK_DATA_LSB];
  assign progEnd = (state == ST_PROG) && (progCount == 8'h01);

  section_access_check u_store_check (
    .isStore(1'b1),
    .execInLoader(execInLoader),
    .targetInLoader(targetInLoader),
    .appLock(lockBits[1:0]),
    .bootLock(lockBits[3:2]),
    .allow(storeAllow)
  );

  section_access_check u_load_check (
    .isStore(1'b0),
    .execInLoader(execInLoader),
    .targetInLoader(targetInLoader),
    .appLock(lockBits[1:0]),
    .bootLock(lockBits[3:2]),
    .allow(loadAllow)
  );

  lock_bit_store u_locks (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .loadNv(nvPending),
    .nvBits(nvLockBits),
    .progStrobe(lockStrobe),
    .progMask(lockMask),
    .extStrobe(extLockWrite),
    .extMask(extLockData),
    .chipErase(chipErase),
    .lockBits(lockBits)
  );

  // programming sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (startProg) begin
          next_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (progEnd) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      progCount <= 8'h00;
    end else begin
      state <= next_state;
      if (startProg) begin
        progCount <= `PROG_CYCLES;
      end else if (state == ST_PROG) begin
        progCount <= progCount - 8'h01;
      end
    end
  end

  // address latch, held for the whole operation
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latchedPage <= 10'h000;
      latchedWord <= 5'h00;
      progCmd <= CMD_PAGE_ERASE;
    end else if (startProg | (storeTake & isPageLoad)) begin
      latchedPage <= pointer[`PAGE_FIELD_MSB:`PAGE_FIELD_LSB];
      latchedWord <= pointer[`WORD_FIELD_MSB:`WORD_FIELD_LSB];
      progCmd <= storeCmd;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      progStart <= 1'b0;
      progDone <= 1'b0;
      progBusy <= 1'b0;
      wordLoad <= 1'b0;
      storeRefused <= 1'b0;
    end else begin
      progStart <= startProg;
      progDone <= progEnd;
      progBusy <= next_state == ST_PROG;
      wordLoad <= storeTake & isPageLoad;
      storeRefused <= storeFromApp | (storeReq & execInLoader & (state != ST_IDLE))
        | (storeTake & isProgCmd & ~storeAllow);
    end
  end

  // loads: byte addressed, judged against the target lock pair
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      loadGrant <= 1'b0;
      loadRefused <= 1'b0;
      loadByteAddr <= 16'h0000;
      loadHighByte <= 1'b0;
    end else begin
      loadGrant <= loadReq & loadAllow;
      loadRefused <= loadReq & ~loadAllow;
      if (loadReq & loadAllow) begin
        loadByteAddr <= pointer;
        loadHighByte <= pointer[0];
      end
    end
  end

  // interrupt suppression
  assign appVecCase = ~lockBits[1] & vectorsInLoader & ~execInLoader;
  assign bootVecCase = ~lockBits[3] & ~vectorsInLoader & execInLoader;
  assign next_intSuppress = appVecCase | bootVecCase;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      intSuppress <= 1'b0;
    end else begin
      intSuppress <= next_intSuppress;
    end
  end

  // fuse: written only by the external programmer, no path from the core
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bootResetFuse <= `FUSE_ERASED;
    end else if (nvPending) begin
      bootResetFuse <= nvBootResetFuse;
    end else if (extFuseWrite) begin
      bootResetFuse <= extFuseData;
    end
  end

  // reset vector follows the captured fuse
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resetVector <= `APP_RESET_ADDR;
    end else begin
      resetVector <= (nvPending ? nvBootResetFuse : extFuseWrite ? extFuseData : bootResetFuse)
        ? `APP_RESET_ADDR : `LOADER_START_WORD;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockImage <= `LOCK_ERASED;
    end else begin
      lockImage <= lockBits;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_progLaunch;
    storeReq && execInLoader && (state == ST_IDLE) && isProgCmd && storeAllow;
  endsequence

  sequence s_progRun;
    progStart ##(`PROG_CYCLES) progDone;
  endsequence

  property p_fullProgram;
    s_progLaunch |=> s_progRun;
  endproperty

  AST_PROG_SEQUENCE: assert property (p_fullProgram)
    else $error("erase or write did not run its full length");

  AST_APP_STORE_DROPPED: assert property (storeReq && !execInLoader
    |=> storeRefused && !progStart && !wordLoad)
    else $error("store from application section had an effect");

  AST_LATCH_HOLDS: assert property (progStart |=> $stable(latchedPage) [*7])
    else $error("latched page moved during programming");

  AST_PAGE_FROM_POINTER: assert property (startProg
    |=> latchedPage == $past(pointer[15:6]) && latchedWord == $past(pointer[5:1]))
    else $error("latched address does not match pointer");

  AST_APP_WRITE_LOCK: assert property (storeReq && execInLoader && !targetInLoader
    && !lockBits[0] && isProgCmd |=> !progStart && storeRefused)
    else $error("store into locked application section started");

  AST_BOOT_WRITE_LOCK: assert property (storeReq && execInLoader && targetInLoader
    && !lockBits[2] && isProgCmd |=> !progStart)
    else $error("store into locked loader section started");

  AST_APP_READ_LOCK: assert property (loadReq && execInLoader && !targetInLoader
    && !lockBits[1] |=> loadRefused && !loadGrant)
    else $error("cross-section load of application section allowed");

  AST_BOOT_READ_LOCK: assert property (loadReq && !execInLoader && targetInLoader
    && !lockBits[3] |=> loadRefused && !loadGrant)
    else $error("cross-section load of loader section allowed");

  AST_UNLOCKED_LOAD: assert property (loadReq && lockBits == 4'hf
    |=> loadGrant && loadByteAddr == $past(pointer) && loadHighByte == $past(pointer[0]))
    else $error("load refused or misaddressed with no locks");

  AST_LOCK_ONLY_ERASED_BY_CHIP: assert property (!chipErase && !nvPending
    |=> (lockBits & ~$past(lockBits)) == 4'h0)
    else $error("lock bit returned to unprogrammed without chip erase");

  AST_LOCK_SET_NO_POINTER: assert property (lockStrobe && !chipErase && !extLockWrite
    && !nvPending |=> lockBits == ($past(lockBits) & $past(lockMask)))
    else $error("lock set result depends on more than the data byte");

  AST_INT_SUPPRESS: assert property (!lockBits[1] && vectorsInLoader && !execInLoader
    |=> intSuppress)
    else $error("interrupts not suppressed in application section");

  AST_INT_SUPPRESS_BOOT: assert property (!lockBits[3] && !vectorsInLoader && execInLoader
    |=> intSuppress)
    else $error("interrupts not suppressed in loader section");

  AST_FUSE_STABLE: assert property (!extFuseWrite && !nvPending |=> $stable(bootResetFuse))
    else $error("fuse changed without external programming");

  AST_RESET_VECTOR: assert property (!nvPending && !extFuseWrite
    |=> resetVector == (bootResetFuse ? `APP_RESET_ADDR : `LOADER_START_WORD))
    else $error("reset vector does not follow fuse");

  // busy covers the whole run, then drops in the done cycle
  sequence s_busyHeld;
    progBusy [*7];
  endsequence

  sequence s_busyDrop;
    progDone && !progBusy;
  endsequence

  AST_BUSY_SPAN: assert property (progStart |=> s_busyHeld ##1 s_busyDrop)
    else $error("busy does not span the programming run");

  AST_CMD_LATCHED: assert property (startProg
    |=> progCmd == $past(storeCmd) && progBusy)
    else $error("command not latched at programming start");

  AST_STORE_WHILE_BUSY: assert property (storeReq && execInLoader && (state != ST_IDLE)
    |=> storeRefused && !progStart && !wordLoad)
    else $error("store accepted while an operation runs");

  AST_PAGE_LOAD_WORD: assert property (storeTake && isPageLoad
    |=> wordLoad && latchedWord == $past(pointer[5:1]))
    else $error("page load word address wrong");

  AST_UNLOCKED_STORE: assert property (storeReq && execInLoader && (state == ST_IDLE)
    && isProgCmd && (lockBits == `LOCK_ERASED) |=> progStart && !storeRefused)
    else $error("store refused with no locks set");

  AST_SAME_SECTION_LOAD: assert property (loadReq && (execInLoader == targetInLoader)
    |=> loadGrant && !loadRefused)
    else $error("load inside own section refused");

  AST_CHIP_ERASE_CLEARS: assert property (chipErase |=> lockBits == `LOCK_ERASED)
    else $error("chip erase left a lock bit programmed");

endmodule // boot_lock_flash_guard

// ### testbench/cpu_core_model.sv
`timescale 1ns/10ps
module cpu_core_model (
  input wire logic core_clk, // system clock
  output logic [14:0] execPc, // running code word address
  output logic vectorsInLoader, // vector table placement
  output logic [7:0] pointerHighByte, // pointer high byte
  output logic [7:0] pointerLowByte, // pointer low byte
  output logic storeReq, // store issue pulse
  output boot_lock_pkg::store_cmd_t storeCmd, // store command
  output logic [7:0] storeData, // lock set data
  output logic loadReq // load issue pulse
);
  import boot_lock_pkg::*;
  initial begin
    execPc = 15'h0000;
    vectorsInLoader = 1'b0;
    {pointerHighByte, pointerLowByte} = 16'h0000;
    storeReq = 1'b0;
    storeCmd = CMD_PAGE_LOAD;
    storeData = 8'hff;
    loadReq = 1'b0;
  end
  // context only; pointer is a register, so it simply keeps its value
  task automatic place(input logic [14:0] pc, input logic vec, input logic [15:0] ptr);
    @(posedge core_clk);
    execPc <= pc;
    vectorsInLoader <= vec;
    {pointerHighByte, pointerLowByte} <= ptr;
  endtask
  // one instruction per call; returns just after the answer edge
  task automatic store(input logic [14:0] pc, input logic [15:0] ptr, input store_cmd_t cmd,
                       input logic [7:0] data);
    place(pc, vectorsInLoader, ptr);
    storeReq <= 1'b1;
    storeCmd <= cmd;
    storeData <= data;
    @(posedge core_clk);
    storeReq <= 1'b0;
    #1;
  endtask
  task automatic load(input logic [14:0] pc, input logic [15:0] ptr);
    place(pc, vectorsInLoader, ptr);
    loadReq <= 1'b1;
    @(posedge core_clk);
    loadReq <= 1'b0;
    #1;
  endtask
endmodule // cpu_core_model

// ### testbench/testbench.sv
`timescale 1ns/10ps
`include "boot_lock_regs.svh"
module testbench;
  import boot_lock_pkg::*;
  logic core_clk, sys_rst, nvBootResetFuse, chipErase, extLockWrite, extFuseWrite, extFuseData;
  logic [3:0] nvLockBits, extLockData, lockImage;
  logic [14:0] execPc, resetVector;
  logic vectorsInLoader, storeReq, loadReq, progStart, progDone, progBusy, wordLoad;
  logic storeRefused, loadGrant, loadRefused, loadHighByte, intSuppress, bootResetFuse;
  logic [7:0] pointerHighByte, pointerLowByte, storeData;
  store_cmd_t storeCmd, progCmd;
  logic [9:0] latchedPage;
  logic [4:0] latchedWord;
  logic [15:0] loadByteAddr;
  int errCount, compares, cycles;
  logic [1:0] modes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};

  cpu_core_model cpu (.core_clk(core_clk), .execPc(execPc), .vectorsInLoader(vectorsInLoader),
    .pointerHighByte(pointerHighByte), .pointerLowByte(pointerLowByte), .storeReq(storeReq),
    .storeCmd(storeCmd), .storeData(storeData), .loadReq(loadReq));
  boot_lock_flash_guard DUT (.core_clk(core_clk), .sys_rst(sys_rst), .nvLockBits(nvLockBits),
    .nvBootResetFuse(nvBootResetFuse), .chipErase(chipErase), .extLockWrite(extLockWrite),
    .extLockData(extLockData), .extFuseWrite(extFuseWrite), .extFuseData(extFuseData),
    .execPc(execPc), .vectorsInLoader(vectorsInLoader), .pointerHighByte(pointerHighByte),
    .pointerLowByte(pointerLowByte), .storeReq(storeReq), .storeCmd(storeCmd),
    .storeData(storeData), .loadReq(loadReq), .progStart(progStart), .progDone(progDone),
    .progBusy(progBusy), .progCmd(progCmd), .latchedPage(latchedPage),
    .latchedWord(latchedWord), .wordLoad(wordLoad), .storeRefused(storeRefused),
    .loadGrant(loadGrant), .loadRefused(loadRefused), .loadByteAddr(loadByteAddr),
    .loadHighByte(loadHighByte), .intSuppress(intSuppress), .resetVector(resetVector),
    .lockImage(lockImage), .bootResetFuse(bootResetFuse));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d, compares %0d", errCount, compares);
    if (errCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // erase first, so the written mask is exactly the image
  task automatic set_locks(input logic [3:0] img);
    @(posedge core_clk);
    chipErase <= 1'b1;
    @(posedge core_clk);
    chipErase <= 1'b0;
    extLockWrite <= 1'b1;
    extLockData <= img;
    @(posedge core_clk);
    extLockWrite <= 1'b0;
    edges(2);
    check(lockImage, img, "lock image");
  endtask

  task automatic write_fuse(input logic v);
    @(posedge core_clk);
    extFuseWrite <= 1'b1;
    extFuseData <= v;
    @(posedge core_clk);
    extFuseWrite <= 1'b0;
    edges(1);
  endtask

  task automatic test_fuse();
    write_fuse(1'b0);
    check(resetVector, `LOADER_START_WORD, "vector, fuse 0");
    cpu.store(15'h3800, 16'h0001, CMD_LOCK_SET, 8'hff);
    edges(1);
    check(bootResetFuse, 1'b0, "fuse after software store");
    write_fuse(1'b1);
    check(resetVector, `APP_RESET_ADDR, "vector, fuse 1");
  endtask

  task automatic test_prog();
    cpu.store(15'h0100, 16'h1234, CMD_PAGE_ERASE, 8'hff);
    check(storeRefused, 1'b1, "store from app");
    check(progStart, 1'b0, "start from app");
    cpu.store(15'h3800, 16'h1234, CMD_PAGE_LOAD, 8'hff);
    check(wordLoad, 1'b1, "page load");
    check(latchedWord, 5'h1a, "word field");
    cpu.store(15'h3800, 16'h0fc2, CMD_PAGE_ERASE, 8'hff);
    check(progStart, 1'b1, "erase start");
    check(latchedPage, 10'h03f, "page field");
    cpu.place(15'h3800, 1'b0, 16'hffff);
    edges(6);
    check(progBusy, 1'b1, "busy before done");
    edges(1);
    check(progDone, 1'b1, "erase done");
    check(latchedPage, 10'h03f, "page held");
    // write reuses the erase pointer so both hit one page
    cpu.store(15'h3800, 16'h0fc2, CMD_PAGE_WRITE, 8'hff);
    check(progCmd, CMD_PAGE_WRITE, "write cmd");
    cpu.store(15'h3800, 16'h0fc2, CMD_PAGE_ERASE, 8'hff);
    check(storeRefused, 1'b1, "store while busy");
    edges(6);
    check(progDone, 1'b1, "write done");
    cpu.load(15'h3800, 16'h0fc2);
    check(loadByteAddr, 16'h0fc2, "even byte address");
    check(loadHighByte, 1'b0, "low byte select");
  endtask

  task automatic test_lock_set();
    cpu.store(15'h3800, 16'hffff, CMD_LOCK_SET, 8'hfb);
    edges(1);
    check(lockImage, 4'he, "lock set ignores pointer");
    cpu.store(15'h3800, 16'h0000, CMD_LOCK_SET, 8'hff);
    edges(1);
    check(lockImage, 4'he, "software cannot clear");
    set_locks(4'hf);
  endtask

  task automatic test_modes();
    logic [1:0] a;
    logic [1:0] b;
    for (int m = 0; m < 4; m++) begin
      a = modes[m];
      b = modes[3-m];
      set_locks({b, a});
      cpu.store(15'h3800, 16'h0140, CMD_PAGE_ERASE, 8'hff);
      check(storeRefused, !a[0], "store into app");
      if (progStart === 1'b1) edges(8);
      cpu.store(15'h3800, 16'h7040, CMD_PAGE_ERASE, 8'hff);
      check(storeRefused, !b[0], "store into loader");
      if (progStart === 1'b1) edges(8);
      cpu.load(15'h3800, 16'h0141);
      check(loadRefused, !a[1], "load app from loader");
      cpu.load(15'h0100, 16'h7041);
      check(loadRefused, !b[1], "load loader from app");
      cpu.load(15'h0100, 16'h0141);
      check(loadGrant, 1'b1, "same section load");
      check(loadByteAddr, 16'h0141, "byte address");
      check(loadHighByte, 1'b1, "byte select");
      cpu.place(15'h0100, 1'b1, 16'h0000);
      edges(1);
      check(intSuppress, !a[1], "irq in app");
      cpu.place(15'h3800, 1'b0, 16'h0000);
      edges(1);
      check(intSuppress, !b[1], "irq in loader");
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // whole run is well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errCount++;
      give_verdict();
    end
  end

  initial begin
    sys_rst = 1'b1;
    nvLockBits = 4'hf;
    nvBootResetFuse = 1'b1;
    chipErase = 1'b0;
    extLockWrite = 1'b0;
    extLockData = 4'hf;
    extFuseWrite = 1'b0;
    extFuseData = 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    edges(2);
    check(resetVector, `APP_RESET_ADDR, "reset vector");
    check(lockImage, 4'hf, "reset lock image");
    test_fuse();
    test_prog();
    test_lock_set();
    test_modes();
    give_verdict();
  end
endmodule // testbench
